// File: hdl/lsf_ctrl.sv
// Top-level control of the three-channel LED current-sink driver
`timescale 1ns/100ps
module lsf_ctrl
    import lsf_pkg::*;
#(
    parameter int P_IDLE_CYC = IDLE_CYC,
    parameter int P_DG_CYC = DG_CYC,
    parameter int P_HIC_CYC = HIC_CYC,
    parameter int P_SS_CYC = SS_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_dim_in_ch1,
    input wire logic i_dim_in_ch2,
    input wire logic i_dim_in_ch3,
    input wire logic [NCH-1:0] i_short_cmp,
    input wire logic [NCH-1:0] i_open_cmp,
    input wire logic i_otp_shdn,
    input wire logic i_otp_rec,
    input wire logic i_undervoltage_lockout,
    input wire logic i_fault_out_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic o_sink_out_ch1,
    output logic o_sink_out_ch2,
    output logic o_sink_out_ch3,
    output logic [LVL_W-1:0] o_ramp_level,
    output logic o_standby,
    output logic o_fault_out_n_o,
    output logic o_fault_out_n_oe,
    output logic o_irq,
    output logic [DATA_W-1:0] o_rdata
);
    localparam int IDLE_W = $clog2(P_IDLE_CYC + 1);
    localparam int SS_W = $clog2(P_SS_CYC + 1);
    localparam int STEP = (P_SS_CYC / LVL_STEPS > 0) ? P_SS_CYC / LVL_STEPS : 1;
    localparam int STEP_W = $clog2(STEP + 1);
    localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(P_IDLE_CYC - 1);
    localparam logic [SS_W-1:0] SS_LAST = SS_W'(P_SS_CYC - 1);
    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP - 1);
    localparam logic [LVL_W-1:0] LVL_MAX = '1;

    logic [NCH-1:0] dim, short_f, open_f;
    logic arm, any_dim, any_fault, shut, idle_done;

    lsf_state_e state_q, state_d;
    logic [IDLE_W-1:0] idle_q, idle_d;
    logic [SS_W-1:0] ss_q, ss_d;
    logic [STEP_W-1:0] step_q, step_d;
    logic [LVL_W-1:0] lvl_q, lvl_d;
    logic [NCH-1:0] sink_q, sink_d;
    logic otp_q, otp_d, standby_q, standby_d, fault_oe_q, fault_oe_d, fault_lo_q;

    lsf_evt_s evt_now, evt_q, status_q, status_d, mask_q, mask_d;
    logic [EVT_W-1:0] clr;
    logic irq_q, irq_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;

    assign dim = {i_dim_in_ch3, i_dim_in_ch2, i_dim_in_ch1};
    assign arm = (state_q == ST_SOFTSTART) || (state_q == ST_RUN);

    // One short and one open checker per channel
    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
        lsf_fault_dg #(
            .P_DG_CYC(P_DG_CYC),
            .P_HIC_CYC(P_HIC_CYC)
        ) u_short (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_dim(dim[ch]),
            .i_flag(i_short_cmp[ch]),
            .i_arm(arm),
            .o_fault(short_f[ch])
        );
        lsf_fault_dg #(
            .P_DG_CYC(P_DG_CYC),
            .P_HIC_CYC(P_HIC_CYC)
        ) u_open (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_dim(dim[ch]),
            .i_flag(i_open_cmp[ch]),
            .i_arm(arm),
            .o_fault(open_f[ch])
        );
    end

    // Power state, soft-start ramp and sink drive
    always_comb begin
        any_dim = |dim;
        any_fault = (|short_f) || (|open_f);
        shut = i_undervoltage_lockout || otp_q || any_fault;
        idle_done = !any_dim && (idle_q == IDLE_LAST);
        otp_d = i_otp_shdn ? 1'h1 : (i_otp_rec ? 1'h0 : otp_q);
        if (any_dim) begin
            idle_d = '0;
        end else if (idle_done) begin
            idle_d = idle_q;
        end else begin
            idle_d = idle_q + 1'h1;
        end
        state_d = state_q;
        case (state_q)
            ST_STANDBY: begin
                if (shut) begin
                    state_d = ST_SHUTDOWN;
                end else if (any_dim) begin
                    state_d = ST_SOFTSTART;
                end
            end
            ST_SOFTSTART: begin
                if (shut) begin
                    state_d = ST_SHUTDOWN;
                end else if (idle_done) begin
                    state_d = ST_STANDBY;
                end else if (ss_q == SS_LAST) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (shut) begin
                    state_d = ST_SHUTDOWN;
                end else if (idle_done) begin
                    state_d = ST_STANDBY;
                end
            end
            ST_SHUTDOWN: begin
                if (!shut) begin
                    state_d = any_dim ? ST_SOFTSTART : ST_STANDBY;
                end
            end
            default: state_d = ST_STANDBY;
        endcase
        ss_d = (state_q == ST_SOFTSTART) ? ss_q + 1'h1 : '0;
        step_d = '0;
        lvl_d = '0;
        if (state_q == ST_SOFTSTART) begin
            step_d = (step_q == STEP_LAST) ? '0 : step_q + 1'h1;
            lvl_d = lvl_q;
            if (step_q == STEP_LAST && lvl_q != LVL_MAX) begin
                lvl_d = lvl_q + 1'h1;
            end
        end else if (state_q == ST_RUN) begin
            lvl_d = LVL_MAX;
        end
        sink_d = (arm && !shut) ? dim : '0;
        standby_d = (state_d == ST_STANDBY);
        fault_oe_d = shut;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= ST_STANDBY;
            idle_q <= '0;
            ss_q <= '0;
            step_q <= '0;
            lvl_q <= '0;
            sink_q <= '0;
            otp_q <= 1'h0;
            standby_q <= 1'h1;
            fault_oe_q <= 1'h0;
            fault_lo_q <= 1'h0;
        end else begin
            state_q <= state_d;
            idle_q <= idle_d;
            ss_q <= ss_d;
            step_q <= step_d;
            lvl_q <= lvl_d;
            sink_q <= sink_d;
            otp_q <= otp_d;
            standby_q <= standby_d;
            fault_oe_q <= fault_oe_d;
            fault_lo_q <= 1'h0;
        end
    end

    // Event status, mask, interrupt and register reads
    always_comb begin
        evt_now.standby = (state_q == ST_STANDBY);
        evt_now.undervoltage_lockout = i_undervoltage_lockout;
        evt_now.otp = otp_q;
        evt_now.open_f = |open_f;
        evt_now.short_f = |short_f;
        clr = (i_wr && reg_hit(i_addr, REG_STATUS)) ? i_wdata[EVT_W-1:0] : '0;
        // New event beats a simultaneous clear
        status_d = lsf_evt_s'((status_q & ~clr) | (evt_now & ~evt_q));
        mask_d = mask_q;
        if (i_wr && reg_hit(i_addr, REG_MASK)) begin
            mask_d = lsf_evt_s'(i_wdata[EVT_W-1:0]);
        end
        irq_d = |(status_d & mask_d);
        rdata_d = '0;
        if (i_rd) begin
            if (reg_hit(i_addr, REG_STATUS)) begin
                rdata_d = DATA_W'(status_q);
            end else if (reg_hit(i_addr, REG_MASK)) begin
                rdata_d = DATA_W'(mask_q);
            end else if (reg_hit(i_addr, REG_LIVE)) begin
                rdata_d = {2'h0, i_fault_out_n, state_q, sink_q};
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            evt_q <= '0;
            status_q <= '0;
            mask_q <= lsf_evt_s'(MASK_RST[EVT_W-1:0]);
            irq_q <= 1'h0;
            rdata_q <= '0;
        end else begin
            evt_q <= evt_now;
            status_q <= status_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_sink_out_ch1 = sink_q[0];
    assign o_sink_out_ch2 = sink_q[1];
    assign o_sink_out_ch3 = sink_q[2];
    assign o_ramp_level = lvl_q;
    assign o_standby = standby_q;
    assign o_fault_out_n_o = fault_lo_q;
    assign o_fault_out_n_oe = fault_oe_q;
    assign o_irq = irq_q;
    assign o_rdata = rdata_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_standby_entry;
        arm && idle_done && !shut |=> state_q == ST_STANDBY && o_standby;
    endproperty
    a_standby_entry: assert property (p_standby_entry)
        else $error("standby not entered after dim inactivity");

    property p_standby_exit;
        state_q == ST_STANDBY && any_dim && !shut |=> state_q == ST_SOFTSTART ##1 !o_standby;
    endproperty
    a_standby_exit: assert property (p_standby_exit)
        else $error("dim activity did not leave standby");

    property p_ss_run;
        state_q == ST_SOFTSTART && ss_q == SS_LAST && !shut && !idle_done
            |=> state_q == ST_RUN ##1 o_ramp_level == LVL_MAX;
    endproperty
    a_ss_run: assert property (p_ss_run)
        else $error("soft-start did not end in run");

    property p_ss_len;
        state_q == ST_SOFTSTART && ss_q != SS_LAST && !shut && !idle_done
            |=> state_q == ST_SOFTSTART && ss_q == $past(ss_q) + 1'h1;
    endproperty
    a_ss_len: assert property (p_ss_len)
        else $error("soft-start left early");

    property p_follow;
        arm && !shut |=> {o_sink_out_ch3, o_sink_out_ch2, o_sink_out_ch1} == $past(dim);
    endproperty
    a_follow: assert property (p_follow)
        else $error("sink does not follow its dim input");

    property p_fault_off;
        any_fault |=> {o_sink_out_ch3, o_sink_out_ch2, o_sink_out_ch1} == 3'h0;
    endproperty
    a_fault_off: assert property (p_fault_off)
        else $error("sinks on during open or short fault");

    property p_undervoltage_lockout;
        i_undervoltage_lockout |=> !o_sink_out_ch1 && !o_sink_out_ch2 && !o_sink_out_ch3
            && o_fault_out_n_oe;
    endproperty
    a_undervoltage_lockout: assert property (p_undervoltage_lockout)
        else $error("undervoltage not handled");

    property p_otp;
        i_otp_shdn |=> ##1 o_fault_out_n_oe && !o_sink_out_ch1 && !o_sink_out_ch2
            && !o_sink_out_ch3;
    endproperty
    a_otp: assert property (p_otp)
        else $error("overtemperature did not shut sinks");

    property p_otp_restart;
        state_q == ST_SHUTDOWN && !shut && any_dim |=> state_q == ST_SOFTSTART ##1 o_ramp_level == 0;
    endproperty
    a_otp_restart: assert property (p_otp_restart)
        else $error("recovery did not restart through soft-start");

    property p_fault_pin;
        1'h1 |=> o_fault_out_n_oe == $past(shut) && !o_fault_out_n_o;
    endproperty
    a_fault_pin: assert property (p_fault_pin)
        else $error("fault pin does not reflect fault sources");

    property p_no_early_standby;
        arm && !idle_done |=> state_q != ST_STANDBY;
    endproperty
    a_no_early_standby: assert property (p_no_early_standby)
        else $error("standby entered before dim inactivity time");

    property p_sink_off_idle;
        !arm |=> {o_sink_out_ch3, o_sink_out_ch2, o_sink_out_ch1} == 3'h0;
    endproperty
    a_sink_off_idle: assert property (p_sink_off_idle)
        else $error("sink on outside soft-start or run");

    property p_rdata_idle;
        !i_rd |=> o_rdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data present without a read");
endmodule

// File: hdl/lsf_pkg.sv
// Package: timing, register map and types of the LED sink controller
// Contract
// - All dim inputs low 4 ms enters standby
// - Sink pin above 15 V flags short
// - Short confirmed after 7 cycles or 3 ms
// - Short rechecked every 128 ms, channels off
// - Open confirmed after 7 cycles or 3 ms
// - Open rechecked every 128 ms, stay protected
// - Any fault pulls fault output low
// - Fault sources: open, short, overtemp, undervoltage
// - Fault output only pulls low or releases
// - Each sink follows its own dim input
// - Soft-start current ramp lasting 200 us
// - Any dim activity leaves standby
// - Open or short turns all channels off
// - Undervoltage keeps channels off, reports fault
package lsf_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1_000;
    localparam int NCH = 3;
    localparam int T_IDLE_MS = 4;
    localparam int IDLE_CYC = T_IDLE_MS * CYC_PER_MS;
    localparam int T_DG_MS = 3;
    localparam int DG_CYC = T_DG_MS * CYC_PER_MS;
    localparam int DG_DIM_CYCLES = 7;
    localparam int T_HIC_MS = 128;
    localparam int HIC_CYC = T_HIC_MS * CYC_PER_MS;
    localparam int T_SS_US = 200;
    localparam int SS_CYC = T_SS_US * CYC_PER_US;
    localparam int LVL_W = 8;
    localparam int LVL_STEPS = 256;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] REG_LIVE = 8'h08;
    localparam logic [DATA_W-1:0] MASK_RST = 8'h00;

    typedef enum logic [1:0] {ST_STANDBY, ST_SOFTSTART, ST_RUN, ST_SHUTDOWN} lsf_state_e;

    typedef struct packed {
        logic standby;
        logic undervoltage_lockout;
        logic otp;
        logic open_f;
        logic short_f;
    } lsf_evt_s;

    localparam int EVT_W = $bits(lsf_evt_s);

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] off);
        reg_hit = (addr == off);
    endfunction
endpackage

// File: hdl/lsf_fault_dg.sv
// Fault deglitch and hiccup retry for one channel and one fault kind
`timescale 1ns/100ps
module lsf_fault_dg
    import lsf_pkg::*;
#(
    parameter int P_DG_CYC = DG_CYC,
    parameter int P_HIC_CYC = HIC_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_dim,
    input wire logic i_flag,
    input wire logic i_arm,
    output logic o_fault
);
    localparam int DG_W = $clog2(P_DG_CYC + 1);
    localparam int HIC_W = $clog2(P_HIC_CYC + 1);
    localparam logic [DG_W-1:0] DG_LAST = DG_W'(P_DG_CYC - 1);
    localparam logic [HIC_W-1:0] HIC_LAST = HIC_W'(P_HIC_CYC - 1);
    localparam logic [2:0] CYC_LAST = 3'(DG_DIM_CYCLES - 1);

    logic dim_q, dim_d, seen_q, seen_d, fault_q, fault_d;
    logic [2:0] cyc_q, cyc_d;
    logic [DG_W-1:0] tmr_q, tmr_d;
    logic [HIC_W-1:0] hic_q, hic_d;
    logic fall, hit, confirm;

    always_comb begin
        dim_d = i_dim;
        seen_d = seen_q;
        cyc_d = cyc_q;
        tmr_d = '0;
        hic_d = '0;
        fault_d = fault_q;
        fall = dim_q && !i_dim;
        hit = i_arm && i_dim && i_flag;
        confirm = 1'h0;
        if (!fault_q) begin
            if (hit) begin
                seen_d = 1'h1;
                tmr_d = tmr_q + 1'h1;
            end
            // Count dimming pulses in a row that showed the flag
            if (fall) begin
                seen_d = 1'h0;
                cyc_d = seen_q ? cyc_q + 3'h1 : 3'h0;
            end
            confirm = (fall && seen_q && cyc_q == CYC_LAST) || (hit && tmr_q == DG_LAST);
            if (confirm) begin
                fault_d = 1'h1;
                seen_d = 1'h0;
                cyc_d = 3'h0;
                tmr_d = '0;
            end
        end else begin
            hic_d = hic_q + 1'h1;
            if (hic_q == HIC_LAST) begin
                hic_d = '0;
                fault_d = i_flag;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dim_q <= 1'h0;
            seen_q <= 1'h0;
            fault_q <= 1'h0;
            cyc_q <= 3'h0;
            tmr_q <= '0;
            hic_q <= '0;
        end else begin
            dim_q <= dim_d;
            seen_q <= seen_d;
            fault_q <= fault_d;
            cyc_q <= cyc_d;
            tmr_q <= tmr_d;
            hic_q <= hic_d;
        end
    end

    assign o_fault = fault_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_cyc_confirm;
        !fault_q && fall && seen_q && cyc_q == CYC_LAST |=> o_fault;
    endproperty
    a_cyc_confirm: assert property (p_cyc_confirm)
        else $error("seventh flagged dim cycle did not confirm fault");

    property p_tmr_confirm;
        !fault_q && hit && tmr_q == DG_LAST |=> o_fault;
    endproperty
    a_tmr_confirm: assert property (p_tmr_confirm)
        else $error("continuous flag timer did not confirm fault");

    property p_no_early;
        !fault_q && !(fall && seen_q && cyc_q == CYC_LAST) && !(hit && tmr_q == DG_LAST)
            |=> !o_fault;
    endproperty
    a_no_early: assert property (p_no_early)
        else $error("fault confirmed before deglitch completed");

    property p_hold;
        fault_q && hic_q != HIC_LAST |=> o_fault && hic_q == $past(hic_q) + 1'h1;
    endproperty
    a_hold: assert property (p_hold)
        else $error("fault released between hiccup rechecks");

    property p_release;
        fault_q && hic_q == HIC_LAST |=> o_fault == $past(i_flag);
    endproperty
    a_release: assert property (p_release)
        else $error("hiccup recheck result not applied");
endmodule

// File: tb/lsf_mcu_model.sv
// Controller model: drives the dimming lines and resolves the shared fault wire
`timescale 1ns/100ps
module lsf_mcu_model
    import lsf_pkg::*;
#(
    parameter int P_ON = 500,
    parameter int P_OFF = 100
) (
    input wire logic i_clk,
    input wire logic [NCH-1:0] i_static,
    input wire logic [NCH-1:0] i_pwm,
    input wire logic i_fault_oe,
    input wire logic i_fault_o,
    output logic [NCH-1:0] o_dim,
    output logic o_fault_wire,
    output int o_falls
);
    int ph;
    logic [NCH-1:0] pwm_en;

    initial begin
        ph = 0;
        pwm_en = '0;
        o_dim = '0;
        o_falls = 0;
    end

    // Enables latched in the last off cycle so every pulse is whole
    always @(posedge i_clk) begin
        ph <= (ph == P_ON + P_OFF - 1) ? 0 : ph + 1;
        if (ph == P_ON + P_OFF - 1) begin
            pwm_en <= i_pwm;
        end
        o_dim <= i_static | (pwm_en & {NCH{ph < P_ON}});
        if (ph == P_ON - 1 && |pwm_en) begin
            o_falls <= o_falls + 1;
        end
    end

    // External pull-up holds the wire high unless a device pulls it low
    assign o_fault_wire = i_fault_oe ? i_fault_o : 1'b1;
endmodule

// File: tb/lsf_ctrl_tb_top.sv
// Self-checking testbench of the LED sink controller
`timescale 1ns/100ps
module lsf_ctrl_tb_top
    import lsf_pkg::*;
();
    localparam int IDLE = 200;
    localparam int DG = 2000;
    localparam int HIC = 3000;
    localparam int SS = 512;

    logic i_clk, i_rst, otp_shdn, otp_rec, undervoltage_lockout, wr, rd, standby, f_o, f_oe, irq, wire_lvl;
    logic [NCH-1:0] dim, short_cmp, open_cmp, dim_static, dim_pwm, sink;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, d;
    logic [LVL_W-1:0] ramp;
    logic [DATA_W-1:0] exp_q[$];
    int falls, n_errors, n_tests, seed;

    lsf_ctrl #(.P_IDLE_CYC(IDLE), .P_DG_CYC(DG), .P_HIC_CYC(HIC), .P_SS_CYC(SS)) i_dut (
        .i_clk(i_clk), .i_rst(i_rst),
        .i_dim_in_ch1(dim[0]), .i_dim_in_ch2(dim[1]), .i_dim_in_ch3(dim[2]),
        .i_short_cmp(short_cmp), .i_open_cmp(open_cmp), .i_otp_shdn(otp_shdn),
        .i_otp_rec(otp_rec), .i_undervoltage_lockout(undervoltage_lockout), .i_fault_out_n(wire_lvl),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_sink_out_ch1(sink[0]), .o_sink_out_ch2(sink[1]), .o_sink_out_ch3(sink[2]),
        .o_ramp_level(ramp), .o_standby(standby), .o_fault_out_n_o(f_o),
        .o_fault_out_n_oe(f_oe), .o_irq(irq), .o_rdata(rdata));

    lsf_mcu_model i_mcu (.i_clk(i_clk), .i_static(dim_static), .i_pwm(dim_pwm),
        .i_fault_oe(f_oe), .i_fault_o(f_o), .o_dim(dim), .o_fault_wire(wire_lvl),
        .o_falls(falls));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    // Sel 0 fault enable, 1 standby, 2 ramp at full scale
    task automatic wait_for(input int sel, input logic want, input int max);
        logic v;
        n_tests++;
        for (int i = 0; i <= max; i++) begin
            tick(1);
            case (sel)
                0: v = f_oe;
                1: v = standby;
                default: v = (ramp === 8'hFF);
            endcase
            if (v === want) return;
        end
        n_errors++;
        $display("FAIL t=%0t wait %h got=%h exp=%h", $time, sel, v, want);
        results();
    endtask

    task automatic wait_falls(input int n);
        int goal;
        goal = falls + n;
        for (int i = 0; i < (n + 2) * 600; i++) begin
            if (falls >= goal) return;
            tick(1);
        end
        n_errors++;
        $display("FAIL t=%0t pulses got=%h exp=%h", $time, falls, goal);
        results();
    endtask

    initial begin
        seed = 32'h22f1;
        n_errors = 0;
        n_tests = 0;
        i_rst = 1'b1;
        {otp_shdn, otp_rec, undervoltage_lockout, wr, rd} = '0;
        {short_cmp, open_cmp, dim_static, dim_pwm} = '0;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        tick(1);
        chk({1'b0, sink, standby, f_oe, f_o, irq}, 8'h08);
        rd_chk(REG_MASK, MASK_RST);
        rd_chk(REG_STATUS, 8'h10);
        wr_reg(REG_STATUS, 8'h1F);
        // Random mask values, unmapped and read-only places
        repeat (4) begin
            d = 8'($random(seed));
            wr_reg(REG_MASK, d);
            exp_q.push_back(d & 8'h1F);
            wr_reg(8'h0C, d);
            rd_chk(REG_MASK, exp_q.pop_front());
            rd_chk(8'h0C, 8'h00);
        end
        wr_reg(REG_LIVE, 8'hFF);
        rd_chk(REG_LIVE, 8'h20);
        wr_reg(REG_MASK, 8'h00);
        // Wake from standby and soft-start
        tick(1);
        dim_static <= 3'b001;
        wait_for(1, 1'b0, 3);
        tick(2);
        chk({5'b0, sink}, 8'h01);
        tick(SS - 20);
        chk({7'b0, ramp === 8'hFF}, 8'h00);
        wait_for(2, 1'b1, 30);
        dim_static <= 3'b110;
        tick(2);
        chk({5'b0, sink}, 8'h06);
        rd_chk(REG_LIVE, 8'h36);
        // Idle entry to standby and interrupt path
        tick(1);
        dim_static <= 3'b000;
        tick(IDLE - 10);
        chk({7'b0, standby}, 8'h00);
        wait_for(1, 1'b1, 15);
        chk({5'b0, sink}, 8'h00);
        rd_chk(REG_STATUS, 8'h10);
        chk({7'b0, irq}, 8'h00);
        wr_reg(REG_MASK, 8'h10);
        tick(1);
        chk({7'b0, irq}, 8'h01);
        wr_reg(REG_STATUS, 8'h10);
        tick(1);
        chk({7'b0, irq}, 8'h00);
        wr_reg(REG_MASK, 8'h0F);
        // Short held with dimming high, then hiccup recheck
        tick(1);
        dim_static <= 3'b011;
        wait_for(2, 1'b1, SS + 20);
        short_cmp <= 3'b001;
        tick(DG - 5);
        chk({7'b0, f_oe}, 8'h00);
        wait_for(0, 1'b1, 10);
        chk({5'b0, sink}, 8'h00);
        chk({7'b0, irq}, 8'h01);
        rd_chk(REG_LIVE, 8'h18);
        rd_chk(REG_STATUS, 8'h01);
        tick(HIC + 20);
        chk({7'b0, f_oe}, 8'h01);
        short_cmp <= 3'b000;
        wait_for(0, 1'b0, HIC + 10);
        wr_reg(REG_STATUS, 8'h1F);
        // Open counted over dimming pulses
        tick(1);
        dim_static <= 3'b010;
        dim_pwm <= 3'b001;
        // Let the static high level end before the flag rises
        tick(2);
        open_cmp <= 3'b001;
        wait_falls(6);
        tick(10);
        chk({7'b0, f_oe}, 8'h00);
        wait_falls(1);
        wait_for(0, 1'b1, 10);
        chk({5'b0, sink}, 8'h00);
        rd_chk(REG_STATUS, 8'h02);
        open_cmp <= 3'b000;
        wait_for(0, 1'b0, HIC + 10);
        dim_pwm <= 3'b000;
        wr_reg(REG_STATUS, 8'h1F);
        // Undervoltage lockout
        tick(1);
        undervoltage_lockout <= 1'b1;
        tick(2);
        chk({4'b0, f_oe, sink}, 8'h08);
        rd_chk(REG_STATUS, 8'h08);
        undervoltage_lockout <= 1'b0;
        wait_for(0, 1'b0, 5);
        wr_reg(REG_STATUS, 8'h1F);
        // Thermal shutdown and recovery
        wait_for(2, 1'b1, SS + 20);
        otp_shdn <= 1'b1;
        tick(1);
        otp_shdn <= 1'b0;
        tick(2);
        chk({4'b0, f_oe, sink}, 8'h08);
        rd_chk(REG_STATUS, 8'h04);
        otp_rec <= 1'b1;
        tick(1);
        otp_rec <= 1'b0;
        wait_for(0, 1'b0, 5);
        tick(2);
        chk({7'b0, ramp === 8'hFF}, 8'h00);
        wait_for(2, 1'b1, SS + 20);
        results();
    end
endmodule
